// ### common/aaol_pkg.sv
// Constants and types for the airflow alarm and output block
package aaol_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ = 25_000_000; // System clock, Hz
    localparam int unsigned TICK_S = 1; // Persistence tick, seconds
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
    localparam int unsigned ROTATE_S = 2; // Display slot, seconds
    localparam int unsigned ROTATE_TICKS = ROTATE_S / TICK_S;
    // Reset values
    localparam logic [12:0] CTRL_RST = 13'h1000; // Idle level high
    localparam logic [15:0] DELAY_RST = 16'h0078; // 2 minutes, seconds
    localparam logic [7:0] BAND_RST = 8'h0A; // 10 percent
    localparam logic [15:0] UNITY_Q8 = 16'h0100; // Gain of one, Q8.8
    localparam logic [15:0] SPAN1_RST = 16'h1388; // Flow span top
    localparam logic [15:0] SPAN2BOT_RST = 16'h0000; // Temp span bottom
    localparam logic [15:0] SPAN2TOP_RST = 16'h00A0; // Temp span top
    // Scaling
    localparam logic [7:0] PCT_FULL = 8'h64; // 100 percent
    localparam logic [15:0] MA_ZERO = 16'h3333; // 4 mA of 20 mA
    localparam logic [15:0] MA_SPAN = 16'hCCCC; // 16 mA of 20 mA
    localparam logic [15:0] CODE_MAX = 16'hFFFF; // Full-scale code
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TARGET = 8'h04;
    localparam logic [7:0] OFS_BAND = 8'h08;
    localparam logic [7:0] OFS_CUTOFF = 8'h0C;
    localparam logic [7:0] OFS_SPAN1 = 8'h10;
    localparam logic [7:0] OFS_SPAN2BOT = 8'h14;
    localparam logic [7:0] OFS_SPAN2TOP = 8'h18;
    localparam logic [7:0] OFS_AREA = 8'h1C;
    localparam logic [7:0] OFS_ELEV = 8'h20;
    localparam logic [7:0] OFS_DELAY = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_CLEAR = 8'h2C;
    localparam logic [7:0] OFS_LOCK = 8'h30;
    localparam logic [7:0] OFS_CODE = 8'h34;
    localparam logic [7:0] OFS_UNLOCK = 8'h38;
    localparam int unsigned LOCK_BIT = 8; // Engage bit in lock word
    // Modes
    typedef enum logic [1:0] {PROT_LOW, PROT_MED, PROT_HIGH} aaol_prot_t;
    typedef enum logic [1:0] {ROLE_TEMP, ROLE_AVG, ROLE_FAULT} aaol_role_t;
    typedef enum logic [1:0] {RANGE_MA, RANGE_10V, RANGE_5V} aaol_range_t;
    typedef enum logic [1:0] {
        ITEM_FLOW, ITEM_UNDER, ITEM_OVER, ITEM_FAULT
    } aaol_item_t;
    // Control word, MSB first
    typedef struct packed {
        logic idleHigh;
        logic manualReset;
        logic nullSuppress;
        logic standardMode;
        logic volumetricOut;
        logic volumetricLcd;
        aaol_range_t outRange;
        aaol_role_t role;
        logic faultEn;
        logic overEn;
        logic underEn;
    } aaol_ctrl_t;
    // Display feed
    typedef struct packed {
        logic faultBanner;
        aaol_item_t item;
        logic [15:0] value;
    } aaol_disp_t;
endpackage : aaol_pkg

// ### rtl/aaol_top.sv
// Airflow alarm evaluation, analog output scaling and display rotation
//
// Behaviour
// [R1] Under alarm below target minus band margin
// [R2] Under alarm clears only above that threshold
// [R3] Over alarm above target plus band margin
// [R4] Over alarm clears only below that threshold
// [R5] Second output role picks temperature, flow alarm or fault alarm
// [R6] Display rotates alarms then flow, 2 s
// [R7] Idle polarity sets normal extreme, alarm opposite
// [R8] Fault banner shown whenever fault exists
// [R9] Each alarm enabled independently
// [R10] Low level uses serial last four digits
// [R11] Medium/high use confirmed code; block writes
// [R12] Actual mode applies elevation; standard passes
// [R13] Display units never change output units
// [R14] Volumetric first output is velocity times area
// [R15] Milliamp is 4 plus 16 fraction; volts linear
// [R16] Temperature scales span bottom to top linearly
// [R17] Alarm asserts after condition persists delay
// [R18] Auto reset self-clears; manual latches
// [R19] Null suppression blocks under alarm below cutoff
// [R20] Flow below cutoff forced to zero
// [R21] Alarms re-evaluated on each new average
module aaol_top #(
    parameter int unsigned TICK_LEN = aaol_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire logic [15:0] avgFlow,
    input wire logic avgValid,
    input wire logic [15:0] avgTemp,
    input wire logic faultIn,
    input wire logic [15:0] serialDigits,
    output logic [15:0] ao1Code,
    output aaol_pkg::aaol_range_t ao1Range,
    output logic [15:0] ao2Code,
    output logic underAlarm,
    output logic overAlarm,
    output logic faultAlarm,
    output aaol_pkg::aaol_disp_t display,
    output logic configLocked
);
    import aaol_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Declarations
    aaol_ctrl_t ctrl_reg; // Modes and enables
    logic [15:0] target_reg; // Alarm target
    logic [7:0] band_reg; // Band fraction, percent
    logic [15:0] cutoff_reg; // Cutoff floor
    logic [15:0] span1_reg; // First output span top
    logic [15:0] span2Bot_reg; // Second output span bottom
    logic [15:0] span2Top_reg; // Second output span top
    logic [15:0] area_reg; // Free area, Q8.8
    logic [15:0] elev_reg; // Elevation gain, Q8.8
    logic [15:0] delay_reg; // Persistence, seconds
    aaol_prot_t level_reg; // Protection level
    logic [15:0] code_reg; // Confirmed user code
    logic codeSet_reg; // User code present
    logic [15:0] codePend_reg; // Code awaiting confirmation
    logic pendValid_reg; // Pending code held
    logic locked_reg; // Configuration locked
    logic [31:0] rdata_reg; // Read answer
    logic underRaw_reg; // Under condition
    logic overRaw_reg; // Over condition
    logic [2:0] rawVec; // Conditions: fault, over, under
    logic [2:0] alarmVec; // Alarms: fault, over, under
    logic [2:0][15:0] held_reg; // Seconds each condition held
    logic [31:0] tickCnt_reg; // Cycles in the second
    logic tick; // One-second pulse
    logic [7:0] slotCnt_reg; // Ticks in display slot
    logic slotEnd; // Display slot over
    aaol_item_t item_reg; // Item on display
    aaol_disp_t disp_reg; // Display feed
    logic [15:0] ao1_reg; // First output code
    logic [15:0] ao2_reg; // Second output code
    logic wrCfg; // Accepted configuration write
    logic [2:0] clrMask; // Manual alarm clears
    logic [15:0] effCode; // Code that unlocks
    logic [15:0] corrFlow; // Mode-corrected flow
    logic [15:0] cutFlow; // Flow after cutoff
    logic [15:0] outFlow; // First output flow
    logic [15:0] lcdFlow; // Display flow
    logic [15:0] frac1; // First output fraction
    logic [15:0] ao1Next; // First output code
    logic [15:0] ao2Next; // Second output code
    logic [15:0] margin; // Band margin
    logic [15:0] lowThr; // Under threshold
    logic [16:0] highThr; // Over threshold
    logic [7:0] bandClamp; // Band, at most full

    ////////////////////////////////////////////////////////////////////
    // Helpers
    // Q8.8 product, saturated
    function automatic logic [15:0] mulQ8(input logic [15:0] a,
                                          input logic [15:0] b);
        logic [31:0] p;
        p = 32'(a) * 32'(b);
        return (|p[31:24]) ? CODE_MAX : p[23:8];
    endfunction : mulQ8

    // Linear map of lo..hi onto 0..full code, clamped
    function automatic logic [15:0] scale(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        logic [31:0] num;
        num = 32'(v - lo) * 32'(CODE_MAX);
        if (v <= lo || hi <= lo) begin
            return 16'h0000;
        end
        if (v >= hi) begin
            return CODE_MAX;
        end
        return 16'(num / 32'(hi - lo));
    endfunction : scale

    // Next active alarm after the current item, else flow
    function automatic aaol_item_t nextItem(input aaol_item_t cur,
                                            input logic [2:0] act);
        aaol_item_t n;
        n = ITEM_FLOW;
        for (int k = 2; k >= 0; k--) begin
            if (act[k] && (k + 1) > int'(cur)) begin
                n = aaol_item_t'(2'(k + 1));
            end
        end
        return n;
    endfunction : nextItem

    ////////////////////////////////////////////////////////////////////
    // Register access and lock
    assign effCode = (level_reg == PROT_LOW) ? serialDigits : code_reg; // R10
    assign wrCfg = regWrite && !locked_reg; // R11
    assign clrMask = (regWrite && regAddr == OFS_CLEAR) ? regWdata[2:0]
                                                       : 3'h0;

    // Configuration registers, frozen while locked
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= aaol_ctrl_t'(CTRL_RST);
            target_reg <= 16'h0000;
            band_reg <= BAND_RST;
            cutoff_reg <= 16'h0000;
            span1_reg <= SPAN1_RST;
            span2Bot_reg <= SPAN2BOT_RST;
            span2Top_reg <= SPAN2TOP_RST;
            area_reg <= UNITY_Q8;
            elev_reg <= UNITY_Q8;
            delay_reg <= DELAY_RST;
        end else if (wrCfg) begin // R11
            unique case (regAddr)
                OFS_CTRL: ctrl_reg <= aaol_ctrl_t'(regWdata[12:0]);
                OFS_TARGET: target_reg <= regWdata[15:0];
                OFS_BAND: band_reg <= regWdata[7:0];
                OFS_CUTOFF: cutoff_reg <= regWdata[15:0];
                OFS_SPAN1: span1_reg <= regWdata[15:0];
                OFS_SPAN2BOT: span2Bot_reg <= regWdata[15:0];
                OFS_SPAN2TOP: span2Top_reg <= regWdata[15:0];
                OFS_AREA: area_reg <= regWdata[15:0];
                OFS_ELEV: elev_reg <= regWdata[15:0];
                OFS_DELAY: delay_reg <= regWdata[15:0];
                default: ; // Other addresses change nothing here
            endcase
        end
    end

    // Protection level, code entry with confirmation, lock state
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            level_reg <= PROT_LOW;
            code_reg <= 16'h0000;
            codeSet_reg <= 1'b0;
            codePend_reg <= 16'h0000;
            pendValid_reg <= 1'b0;
            locked_reg <= 1'b0;
        end else if (regWrite && regAddr == OFS_UNLOCK) begin
            if (regWdata[15:0] == effCode) begin // R10 R11
                locked_reg <= 1'b0;
            end
        end else if (wrCfg && regAddr == OFS_LOCK) begin
            if (regWdata[1:0] != 2'h3) begin
                level_reg <= aaol_prot_t'(regWdata[1:0]);
            end
            // Medium and high need a confirmed code first
            locked_reg <= regWdata[LOCK_BIT] && (codeSet_reg
                || regWdata[1:0] == 2'(PROT_LOW)); // R11
        end else if (wrCfg && regAddr == OFS_CODE) begin
            if (pendValid_reg && regWdata[15:0] == codePend_reg) begin
                code_reg <= codePend_reg; // R11
                codeSet_reg <= 1'b1;
                pendValid_reg <= 1'b0;
            end else begin
                codePend_reg <= regWdata[15:0];
                pendValid_reg <= 1'b1;
            end
        end
    end

    // Read answer, valid only in the cycle after the strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (!regRead) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            unique case (regAddr)
                OFS_CTRL: rdata_reg <= {19'h0, ctrl_reg};
                OFS_TARGET: rdata_reg <= {16'h0, target_reg};
                OFS_BAND: rdata_reg <= {24'h0, band_reg};
                OFS_CUTOFF: rdata_reg <= {16'h0, cutoff_reg};
                OFS_SPAN1: rdata_reg <= {16'h0, span1_reg};
                OFS_SPAN2BOT: rdata_reg <= {16'h0, span2Bot_reg};
                OFS_SPAN2TOP: rdata_reg <= {16'h0, span2Top_reg};
                OFS_AREA: rdata_reg <= {16'h0, area_reg};
                OFS_ELEV: rdata_reg <= {16'h0, elev_reg};
                OFS_DELAY: rdata_reg <= {16'h0, delay_reg};
                OFS_STATUS: rdata_reg <= {22'h0, locked_reg, item_reg,
                                          faultIn, rawVec, alarmVec};
                OFS_LOCK: rdata_reg <= {23'h0, locked_reg, 5'h0,
                                        codeSet_reg, level_reg};
                default: rdata_reg <= 32'h0000_0000; // Unmapped reads 0
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flow path
    assign corrFlow = ctrl_reg.standardMode ? avgFlow
                                            : mulQ8(avgFlow, elev_reg); // R12
    assign cutFlow = (corrFlow < cutoff_reg) ? 16'h0000 : corrFlow; // R20
    assign outFlow = ctrl_reg.volumetricOut ? mulQ8(cutFlow, area_reg)
                                            : cutFlow; // R14
    assign lcdFlow = ctrl_reg.volumetricLcd ? mulQ8(cutFlow, area_reg)
                                            : cutFlow; // R13
    assign frac1 = scale(outFlow, 16'h0000, span1_reg);
    // Milliamp adds the 4 mA floor; volt ranges are plain fractions
    // Divide by full code so a full fraction lands exactly on 20 mA
    assign ao1Next = (ctrl_reg.outRange == RANGE_MA)
        ? MA_ZERO + 16'((32'(frac1) * 32'(MA_SPAN)) / 32'(CODE_MAX))
        : frac1; // R15

    // Second output by role and idle polarity
    always_comb begin
        unique case (ctrl_reg.role)
            ROLE_AVG: ao2Next = ((alarmVec[0] | alarmVec[1])
                != ctrl_reg.idleHigh) ? CODE_MAX : 16'h0000; // R5 R7
            ROLE_FAULT: ao2Next = (alarmVec[2] != ctrl_reg.idleHigh)
                ? CODE_MAX : 16'h0000; // R5 R7
            default: ao2Next = scale(avgTemp, span2Bot_reg,
                                     span2Top_reg); // R16
        endcase
    end

    // Output codes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ao1_reg <= 16'h0000;
            ao2_reg <= 16'h0000;
        end else begin
            ao1_reg <= ao1Next;
            ao2_reg <= ao2Next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Alarm conditions with hysteresis
    assign bandClamp = (band_reg > PCT_FULL) ? PCT_FULL : band_reg;
    assign margin = 16'((32'(target_reg) * 32'(bandClamp))
                        / 32'(PCT_FULL));
    assign lowThr = target_reg - margin;
    assign highThr = {1'b0, target_reg} + {1'b0, margin};

    // Conditions update only on a new average
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            underRaw_reg <= 1'b0;
            overRaw_reg <= 1'b0;
        end else if (avgValid) begin // R21
            if (!ctrl_reg.underEn) begin // R9
                underRaw_reg <= 1'b0;
            end else if (ctrl_reg.nullSuppress
                         && corrFlow < cutoff_reg) begin // R19
                underRaw_reg <= 1'b0;
            end else if (corrFlow < lowThr) begin // R1
                underRaw_reg <= 1'b1;
            end else if (corrFlow > lowThr) begin // R2
                underRaw_reg <= 1'b0;
            end
            if (!ctrl_reg.overEn) begin // R9
                overRaw_reg <= 1'b0;
            end else if ({1'b0, corrFlow} > highThr) begin // R3
                overRaw_reg <= 1'b1;
            end else if ({1'b0, corrFlow} < highThr) begin // R4
                overRaw_reg <= 1'b0;
            end
        end
    end

    assign rawVec = {ctrl_reg.faultEn && faultIn, overRaw_reg,
                     underRaw_reg}; // R9

    // One-second tick
    assign tick = (tickCnt_reg == TICK_LEN - 1);
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tickCnt_reg <= 32'h0000_0000;
        end else begin
            tickCnt_reg <= tick ? 32'h0000_0000 : tickCnt_reg + 32'h1;
        end
    end

    // Persistence and latching, one lane per alarm
    for (genvar gi = 0; gi < 3; gi++) begin : g_alarm
        // Seconds the condition has held
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                held_reg[gi] <= 16'h0000;
            end else if (!rawVec[gi]) begin
                held_reg[gi] <= 16'h0000;
            end else if (tick && held_reg[gi] != CODE_MAX) begin
                held_reg[gi] <= held_reg[gi] + 16'h1;
            end
        end
        // Set wins over any clear in the same cycle
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                alarmVec[gi] <= 1'b0;
            end else if (rawVec[gi] && held_reg[gi] >= delay_reg) begin
                alarmVec[gi] <= 1'b1; // R17
            end else if (!ctrl_reg.manualReset && !rawVec[gi]) begin
                alarmVec[gi] <= 1'b0; // R18
            end else if (ctrl_reg.manualReset && clrMask[gi]) begin
                alarmVec[gi] <= 1'b0; // R18
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Display rotation
    assign slotEnd = tick && (slotCnt_reg == 8'(ROTATE_TICKS - 1));

    // Item advances at slot end; idle shows flow
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            slotCnt_reg <= 8'h00;
            item_reg <= ITEM_FLOW;
        end else if (alarmVec == 3'h0) begin
            slotCnt_reg <= 8'h00;
            item_reg <= ITEM_FLOW;
        end else if (slotEnd) begin
            slotCnt_reg <= 8'h00;
            item_reg <= nextItem(item_reg, alarmVec); // R6
        end else if (tick) begin
            slotCnt_reg <= slotCnt_reg + 8'h01;
        end
    end

    // Display feed
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            disp_reg <= '0;
        end else begin
            disp_reg.faultBanner <= faultIn; // R8
            disp_reg.item <= item_reg;
            disp_reg.value <= lcdFlow;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign regRdata = rdata_reg;
    assign ao1Code = ao1_reg;
    assign ao1Range = ctrl_reg.outRange;
    assign ao2Code = ao2_reg;
    assign underAlarm = alarmVec[0];
    assign overAlarm = alarmVec[1];
    assign faultAlarm = alarmVec[2];
    assign display = disp_reg;
    assign configLocked = locked_reg;

    ////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_under_in;
        avgValid && ctrl_reg.underEn && !ctrl_reg.nullSuppress
            && corrFlow < lowThr;
    endsequence
    sequence s_over_in;
        avgValid && ctrl_reg.overEn && {1'b0, corrFlow} > highThr;
    endsequence

    a_under_set: assert property (s_under_in |=> underRaw_reg) // R1
        else $error("under condition not raised");
    a_under_clear: assert property ($fell(underRaw_reg) |->
        $past(corrFlow) > $past(lowThr) || !$past(ctrl_reg.underEn)
        || $past(ctrl_reg.nullSuppress)) // R2
        else $error("under condition cleared early");
    a_over_set: assert property (s_over_in |=> overRaw_reg) // R3
        else $error("over condition not raised");
    a_over_clear: assert property ($fell(overRaw_reg) |->
        {1'b0, $past(corrFlow)} < $past(highThr)
        || !$past(ctrl_reg.overEn)) // R4
        else $error("over condition cleared early");
    a_fault_role: assert property (ctrl_reg.role == ROLE_FAULT |=>
        ao2Code == (($past(alarmVec[2]) != $past(ctrl_reg.idleHigh))
        ? CODE_MAX : 16'h0000)) // R5
        else $error("second output ignores fault role");
    a_idle_level: assert property (ctrl_reg.role == ROLE_AVG
        && alarmVec[1:0] == 2'b00 && ctrl_reg.idleHigh
        |=> ao2Code == CODE_MAX) // R7
        else $error("idle level not full scale");
    a_disp_slot: assert property ($changed(item_reg) |->
        $past(slotEnd) || $past(alarmVec) == 3'h0) // R6
        else $error("display changed mid slot");
    a_fault_banner: assert property (faultIn |=>
        display.faultBanner) // R8
        else $error("fault banner missing");
    a_lock_block: assert property (locked_reg && regWrite
        && regAddr == OFS_TARGET |=> $stable(target_reg)) // R11
        else $error("write passed while locked");
    a_persist_due: assert property ($rose(alarmVec[0]) |->
        $past(held_reg[0]) >= $past(delay_reg)) // R17
        else $error("alarm raised before persistence");
    a_auto_clear: assert property (!ctrl_reg.manualReset
        && !rawVec[1] |=> !alarmVec[1]) // R18
        else $error("auto alarm failed to clear");
endmodule : aaol_top

// ### dv/aaol_bas_model.sv
// Controller model reading the second analog output as an alarm contact
module aaol_bas_model (
    clock,
    reset_n,
    ao2Code,
    ao2Low
);
    timeunit 1ns;
    timeprecision 1ns;
    input wire logic clock; // System clock
    input wire logic reset_n; // Async reset, active low
    input wire logic [15:0] ao2Code; // Second output code
    output logic ao2Low; // Output seen in lower half
    ////////////////////////////////////////////////////////////////////////
    // Lower half reads as the alarm extreme when idle is high
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ao2Low <= 1'b0;
        end else begin
            ao2Low <= (ao2Code < 16'h8000);
        end
    end
endmodule : aaol_bas_model

// ### dv/testbench.sv
// Self-checking bench for the airflow alarm and output block
module testbench import aaol_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0; // 25 MHz clock
    logic reset_n = 1'b0; // Reset, active low
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata, rdv;
    logic regWrite = 1'b0, regRead = 1'b0, avgValid = 1'b0;
    logic faultIn = 1'b0, underAlarm, overAlarm, faultAlarm;
    logic configLocked, ao2Low, expU = 1'b0, expO = 1'b0;
    logic [15:0] avgFlow = 16'h0, avgTemp = 16'h0, f;
    logic [15:0] serialDigits = 16'h1234, ao1Code, ao2Code;
    logic [31:0] rng = 32'h7A1C; // Random state
    logic [15:0] corner [6] = '{16'h50, 16'h5A, 16'h5B,
                                16'h6F, 16'h6E, 16'h6D};
    aaol_range_t ao1Range;
    aaol_disp_t display;
    int fails = 0, samples_checked = 0;
    always #20 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    aaol_top #(.TICK_LEN(10)) aaol_top_i (.clock(clock), .reset_n(reset_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .avgFlow(avgFlow),
        .avgValid(avgValid), .avgTemp(avgTemp), .faultIn(faultIn),
        .serialDigits(serialDigits), .ao1Code(ao1Code), .ao1Range(ao1Range),
        .ao2Code(ao2Code), .underAlarm(underAlarm), .overAlarm(overAlarm),
        .faultAlarm(faultAlarm), .display(display),
        .configLocked(configLocked));
    aaol_bas_model aaol_bas_model_i (.clock(clock), .reset_n(reset_n),
        .ao2Code(ao2Code), .ao2Low(ao2Low));
    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            fails++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    // One-cycle register write
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr
    // Register read, data taken in the following cycle
    task rd(input logic [7:0] a);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 rdv = regRdata;
    endtask : rd
    // New averaged sample, then let alarm and outputs settle
    task feed(input logic [15:0] v);
        @(posedge clock);
        avgFlow <= v;
        avgValid <= 1'b1;
        @(posedge clock);
        avgValid <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask : feed
    // Xorshift step
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task give_verdict;
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        #1;
        check(ao1Range, RANGE_MA);
        check(ao1Code, MA_ZERO);
        check(ao2Code, 16'h0000);
        rd(OFS_CTRL);
        check(rdv, CTRL_RST);
        rd(8'h40);
        check(rdv, 32'h0);
        feed(SPAN1_RST);
        check(ao1Code, CODE_MAX);
        wr(OFS_CTRL, 32'h102B);
        wr(OFS_TARGET, 32'h64);
        wr(OFS_DELAY, 32'h0);
        // Corner thresholds first, then random flows around the band
        for (int i = 0; i < 46; i++) begin
            rng = xs(rng);
            f = (i < 6) ? corner[i] : 16'h0046 + 16'(rng % 32'h3D);
            if (f < 16'h5A) expU = 1'b1;
            else if (f > 16'h5A) expU = 1'b0;
            if (f > 16'h6E) expO = 1'b1;
            else if (f < 16'h6E) expO = 1'b0;
            feed(f);
            check(underAlarm, expU);
            check(overAlarm, expO);
            check(ao2Code, (expU | expO) ? 16'h0 : CODE_MAX);
            check(ao2Low, expU | expO);
        end
        feed(16'h0064);
        @(posedge clock);
        faultIn <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        check(display.faultBanner, 1'b1);
        check(faultAlarm, 1'b0);
        wr(OFS_CTRL, 32'h1037);
        repeat (4) @(posedge clock);
        #1;
        check(faultAlarm, 1'b1);
        check(ao2Code, 16'h0);
        // Rotation: fault slot comes within a bound, then flow slot
        for (int i = 0; i < 48 && display.item != ITEM_FAULT; i++) begin
            @(posedge clock);
            #1;
        end
        check(display.item, ITEM_FAULT);
        repeat (20) @(posedge clock);
        #1;
        check(display.item, ITEM_FLOW);
        // Low level lock: writes blocked until serial digits supplied
        wr(OFS_LOCK, 32'h100);
        wr(OFS_TARGET, 32'h50);
        rd(OFS_TARGET);
        check(rdv, 32'h64);
        check(configLocked, 1'b1);
        wr(OFS_UNLOCK, 32'h1234);
        @(posedge clock);
        #1;
        check(configLocked, 1'b0);
        // Cutoff, null suppression, volumetric output, units, modes
        wr(OFS_CUTOFF, 32'h40);
        wr(OFS_AREA, 32'h200);
        wr(OFS_SPAN1, 32'h400);
        wr(OFS_CTRL, 32'h1521);
        feed(16'h003F);
        check(underAlarm, 1'b0);
        check(display.value, 16'h0);
        check(ao1Code, 16'h0);
        feed(16'h0100);
        check(display.value, 16'h0100);
        check(ao1Code, 16'h7FFF);
        wr(OFS_ELEV, 32'h180);
        avgTemp <= 16'h0050;
        feed(16'h0100);
        check(display.value, 16'h0180);
        check(ao2Code, 16'h7FFF);
        wr(OFS_CTRL, 32'h1721);
        feed(16'h0100);
        check(display.value, 16'h0100);
        give_verdict;
    end
endmodule : testbench
